// [common/scp_cfg.svh]
// register map, field positions, reset values and timing counts of the serial port
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
`define SCP_OFF_BAUD 12'h000
`define SCP_OFF_CTRL 12'h004
`define SCP_OFF_STAT1 12'h008
`define SCP_OFF_STAT2 12'h00c
`define SCP_OFF_CTRL3 12'h010
`define SCP_OFF_DATA 12'h014
`define SCP_BAUD_RST 13'h0004
`define SCP_CTRL_RE 0
`define SCP_CTRL_TE 1
`define SCP_CTRL_M 2
`define SCP_CTRL_PE 3
`define SCP_CTRL_LOOP_SELECT 4
`define SCP_CTRL_RECEIVER_SOURCE_SELECT 5
`define SCP_C3_R8 7
`define SCP_C3_T8 6
`define SCP_C3_SINGLE_WIRE_TX_DIRECTION 5
`define SCP_C3_OVERRUN_IRQ_ENABLE 3
`define SCP_C3_NOISE_IRQ_ENABLE 2
`define SCP_C3_FRAMING_IRQ_ENABLE 1
`define SCP_C3_PARITY_IRQ_ENABLE 0
`define SCP_S2_RAF 0
`define SCP_FRAME8 4'h0a
`define SCP_FRAME9 4'h0b
`define SCP_IDLE8 8'h9f
`define SCP_IDLE9 8'haf
`endif

// [common/scp_pkg.sv]
// types shared by the serial port design
package scp_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} scp_rx_st_t;
endpackage : scp_pkg

// [rtl/scp_serial_port.sv]
// serial port: apb registers, baud generator, receiver, transmitter
//
// Behaviour
// - receiver active flag sets on valid start, clears on idle line
// - activity status register is read only; writes change nothing
// - bit 7 of control 3 shows ninth received bit in nine-bit mode
// - data write in nine-bit mode sends nine bits, ninth from control 3 bit 6
// - ninth transmit bit keeps its value across data writes
// - single-wire mode: bit 5 makes transmit pin input (0) or output (1)
// - overrun flag with enable bit 3 requests interrupt
// - noise flag with enable bit 2 requests interrupt
// - framing error flag with enable bit 1 requests interrupt
// - parity error flag with enable bit 0 requests interrupt
// - data address: reads receive buffer, writes transmit buffer
// - data register read after a status 1 read completes automatic flag clearing
// - full duplex: independent transmitter and receiver, one baud generator
// - baud generator divides the bus clock by a programmable modulo
// - receiver realigns bit timing on each falling edge seen after RT11 of a bit in a frame
// - frame is 10 bit times in eight-bit, 11 in nine-bit mode
// - receiver tolerates about 4.5 or 4 percent baud mismatch
// - receiver samples at sixteen times the baud rate
// - word-length bit sizes transmit shifter to 10 or 11 bits
`timescale 1ns/1ps
`include "scp_cfg.svh"
module scp_serial_port
  import scp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rxd_i,
  input wire logic txd_pin_i,
  output logic txd_o,
  output logic txd_oe_o,
  output logic err_irq_o
);
  logic [12:0] baud_q, bcnt_q;
  logic [5:0] ctrl_q;
  logic t8_q, single_wire_tx_direction_q, overrun_irq_enable_q, noise_irq_enable_q, framing_irq_enable_q, parity_irq_enable_q;
  logic pready_q, pslverr_q, irq_q, txd_q, oe_q;
  logic [31:0] prdata_q;
  logic [1:0] rxs_q, pins_q;
  logic bt_q;
  // flags
  logic rdrf_q, idle_q, ovr_q, nf_q, fe_q, pf_q, tdre_q, tc_q, s1_rd_q, idle_arm_q;
  logic [7:0] rbuf_q, tdr_q;
  logic r8_q;

  logic m, acc, wr_fire, rd_fire, s;
  assign m = ctrl_q[`SCP_CTRL_M];
  assign acc = psel_i & penable_i & ~pready_q;
  assign wr_fire = psel_i & penable_i & pready_q & pwrite_i;
  assign rd_fire = psel_i & penable_i & pready_q & ~pwrite_i;

  // two-flop synchronisers on both pins
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      rxs_q <= 2'h3;
      pins_q <= 2'h3;
    end
    else
    begin
      rxs_q <= {rxs_q[0], rxd_i};
      pins_q <= {pins_q[0], txd_pin_i};
    end

  // receiver source: pin, internal loop, or the single-wire pin
  always_comb
    if (!ctrl_q[`SCP_CTRL_LOOP_SELECT])
      s = rxs_q[1];
    else if (ctrl_q[`SCP_CTRL_RECEIVER_SOURCE_SELECT])
      s = pins_q[1];
    else
      s = txd_q;

  // baud modulo counter gives one x16 tick per period, zero stops it
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      bcnt_q <= 13'h0001;
      bt_q <= 1'b0;
    end
    else if (baud_q == 13'h0000)
    begin
      bcnt_q <= 13'h0001;
      bt_q <= 1'b0;
    end
    else if (bcnt_q >= baud_q)
    begin
      bcnt_q <= 13'h0001;
      bt_q <= 1'b1;
    end
    else
    begin
      bcnt_q <= bcnt_q + 13'h0001;
      bt_q <= 1'b0;
    end

  // receiver state
  scp_rx_st_t rx_st_q;
  logic [3:0] rt_q, bit_q, nbits;
  logic [2:0] hist_q, vote_q;
  logic [8:0] shf_q;
  logic noise_q, raf_q, maj, fr_q, fr_nf_q, fr_fe_q, fr_pf_q, idle_hit_q;
  logic [8:0] fr_d_q;
  logic [7:0] idle_cnt_q, idle_lim;
  assign nbits = m ? `SCP_FRAME9 : `SCP_FRAME8;
  assign idle_lim = m ? `SCP_IDLE9 : `SCP_IDLE8;
  assign maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & s) | (vote_q[1] & s);

  // sixteen slots per bit, majority of RT8..RT10, start checked at RT3/5/7
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      rx_st_q <= RX_IDLE;
      rt_q <= 4'h0;
      bit_q <= 4'h0;
      hist_q <= 3'h7;
      vote_q <= 3'h0;
      shf_q <= 9'h000;
      noise_q <= 1'b0;
      fr_q <= 1'b0;
      fr_d_q <= 9'h000;
      fr_nf_q <= 1'b0;
      fr_fe_q <= 1'b0;
      fr_pf_q <= 1'b0;
    end
    else
    begin
      fr_q <= 1'b0;
      if (bt_q && ctrl_q[`SCP_CTRL_RE])
      begin
        hist_q <= {hist_q[1:0], s};
        case (rx_st_q)
          RX_IDLE:
            if (hist_q == 3'h7 && !s)
            begin
              rx_st_q <= RX_START;
              rt_q <= 4'h1;
            end
          RX_START:
          begin
            rt_q <= rt_q + 4'h1;
            if (rt_q == 4'h2 || rt_q == 4'h4 || rt_q == 4'h6)
              vote_q <= {vote_q[1:0], s};
            if (rt_q == 4'h6)
            begin
              // false start: two of three samples high
              if ((vote_q[0] & vote_q[1]) | ((vote_q[0] | vote_q[1]) & s))
                rx_st_q <= RX_IDLE;
              else
              begin
                rx_st_q <= RX_BITS;
                bit_q <= 4'h0;
                noise_q <= vote_q[0] | vote_q[1] | s;
              end
            end
          end
          RX_BITS:
          begin
            rt_q <= rt_q + 4'h1;
            if (rt_q == 4'h7 || rt_q == 4'h8)
              vote_q <= {vote_q[1:0], s};
            if (rt_q > 4'ha && hist_q[0] && !s)
            begin
              rt_q <= 4'h1;
              bit_q <= bit_q + 4'h1;
            end
            else if (rt_q == 4'h9)
            begin
              if (vote_q[0] != vote_q[1] || vote_q[0] != s)
                noise_q <= 1'b1;
              if (bit_q == nbits - 4'h1)
              begin
                // stop bit: hand the frame over, refill edge history
                rx_st_q <= RX_IDLE;
                hist_q <= 3'h7;
                fr_q <= 1'b1;
                fr_d_q <= m ? shf_q : {1'b0, shf_q[8:1]};
                fr_fe_q <= ~maj;
                fr_nf_q <= noise_q | (vote_q[0] != vote_q[1]) | (vote_q[0] != s);
                fr_pf_q <= ctrl_q[`SCP_CTRL_PE] & (^shf_q ^ (~m & shf_q[0]));
              end
              else if (bit_q != 4'h0)
                shf_q <= {maj, shf_q[8:1]};
            end
            else if (rt_q == 4'hf)
              bit_q <= bit_q + 4'h1;
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end

  // activity flag and idle-line count of one full frame of high samples
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      raf_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      idle_hit_q <= 1'b0;
    end
    else
    begin
      idle_hit_q <= 1'b0;
      if (bt_q && rx_st_q == RX_START && rt_q == 4'h6 && !maj)
        raf_q <= 1'b1;
      if (bt_q && ctrl_q[`SCP_CTRL_RE])
      begin
        if (!s)
          idle_cnt_q <= 8'h00;
        else if (idle_cnt_q < idle_lim)
          idle_cnt_q <= idle_cnt_q + 8'h01;
        else if (rx_st_q == RX_IDLE && raf_q)
        begin
          raf_q <= 1'b0;
          idle_hit_q <= 1'b1;
        end
      end
    end

  // receive flags: hardware set wins over the status-then-data clear
  logic rx_clr, load;
  assign rx_clr = rd_fire && paddr_i == `SCP_OFF_DATA && s1_rd_q;
  assign load = fr_q && !rdrf_q && !fe_q;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      rdrf_q <= 1'b0;
      idle_q <= 1'b0;
      ovr_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      pf_q <= 1'b0;
      rbuf_q <= 8'h00;
      r8_q <= 1'b0;
      s1_rd_q <= 1'b0;
      idle_arm_q <= 1'b0;
    end
    else
    begin
      if (rd_fire && paddr_i == `SCP_OFF_STAT1)
        s1_rd_q <= 1'b1;
      else if (rd_fire && paddr_i == `SCP_OFF_DATA)
        s1_rd_q <= 1'b0;
      if (rx_clr)
      begin
        rdrf_q <= 1'b0;
        idle_q <= 1'b0;
        ovr_q <= 1'b0;
        nf_q <= 1'b0;
        fe_q <= 1'b0;
        pf_q <= 1'b0;
      end
      if (fr_q && rdrf_q)
        ovr_q <= 1'b1; // new data lost
      if (load)
      begin
        rbuf_q <= fr_d_q[7:0];
        r8_q <= fr_d_q[8];
        rdrf_q <= 1'b1;
        nf_q <= fr_nf_q;
        fe_q <= fr_fe_q;
        pf_q <= fr_pf_q;
        idle_arm_q <= 1'b1;
      end
      if (idle_hit_q && idle_arm_q)
      begin
        idle_q <= 1'b1;
        idle_arm_q <= 1'b0;
      end
    end

  // transmitter: bit time from sixteen baud ticks
  logic [3:0] trt_q, tcnt_q;
  logic [10:0] tsh_q;
  logic tbit, take;
  assign tbit = bt_q && trt_q == 4'hf;
  assign take = tbit && tcnt_q <= 4'h1 && !tdre_q && ctrl_q[`SCP_CTRL_TE];
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      trt_q <= 4'h0;
      tcnt_q <= 4'h0;
      tsh_q <= 11'h7ff;
    end
    else
    begin
      if (bt_q)
        trt_q <= trt_q + 4'h1;
      if (take)
      begin
        // ninth bit taken at transfer, so it persists across writes
        tsh_q <= m ? {1'b1, t8_q, tdr_q, 1'b0} : {2'h3, tdr_q, 1'b0};
        tcnt_q <= nbits;
      end
      else if (tbit && tcnt_q != 4'h0)
      begin
        tsh_q <= {1'b1, tsh_q[10:1]};
        tcnt_q <= tcnt_q - 4'h1;
      end
    end

  // transmit buffer flags; taking the buffer wins over a write
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      tdre_q <= 1'b1;
      tc_q <= 1'b1;
      tdr_q <= 8'h00;
    end
    else
    begin
      if (wr_fire && paddr_i == `SCP_OFF_DATA)
      begin
        tdr_q <= pwdata_i[7:0];
        tdre_q <= 1'b0;
        tc_q <= 1'b0;
      end
      if (take)
        tdre_q <= 1'b1;
      if (tbit && tcnt_q == 4'h1 && tdre_q)
        tc_q <= 1'b1;
    end

  // pin drive, direction and error interrupt, all registered
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      txd_q <= 1'b1;
      oe_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else
    begin
      txd_q <= (tcnt_q != 4'h0) ? tsh_q[0] : 1'b1;
      oe_q <= ~(ctrl_q[`SCP_CTRL_LOOP_SELECT] & ctrl_q[`SCP_CTRL_RECEIVER_SOURCE_SELECT]) | single_wire_tx_direction_q;
      irq_q <= (ovr_q & overrun_irq_enable_q) | (nf_q & noise_irq_enable_q)
        | (fe_q & framing_irq_enable_q) | (pf_q & parity_irq_enable_q);
    end

  // software-written registers; activity status has no write path
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      baud_q <= `SCP_BAUD_RST;
      ctrl_q <= 6'h00;
      {t8_q, single_wire_tx_direction_q, overrun_irq_enable_q, noise_irq_enable_q, framing_irq_enable_q, parity_irq_enable_q} <= 6'h00;
    end
    else if (wr_fire)
      case (paddr_i)
        `SCP_OFF_BAUD: baud_q <= pwdata_i[12:0];
        `SCP_OFF_CTRL: ctrl_q <= pwdata_i[5:0];
        `SCP_OFF_CTRL3:
        begin
          t8_q <= pwdata_i[`SCP_C3_T8];
          single_wire_tx_direction_q <= pwdata_i[`SCP_C3_SINGLE_WIRE_TX_DIRECTION];
          overrun_irq_enable_q <= pwdata_i[`SCP_C3_OVERRUN_IRQ_ENABLE];
          noise_irq_enable_q <= pwdata_i[`SCP_C3_NOISE_IRQ_ENABLE];
          framing_irq_enable_q <= pwdata_i[`SCP_C3_FRAMING_IRQ_ENABLE];
          parity_irq_enable_q <= pwdata_i[`SCP_C3_PARITY_IRQ_ENABLE];
        end
        default: ;
      endcase

  // apb answer one cycle into the access phase
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (acc)
        case (paddr_i)
          `SCP_OFF_BAUD: prdata_q <= {19'h0_0000, baud_q};
          `SCP_OFF_CTRL: prdata_q <= {26'h000_0000, ctrl_q};
          `SCP_OFF_STAT1:
            prdata_q <= {24'h00_0000, tdre_q, tc_q, rdrf_q, idle_q, ovr_q, nf_q, fe_q, pf_q};
          `SCP_OFF_STAT2: prdata_q <= {31'h0000_0000, raf_q};
          `SCP_OFF_CTRL3:
            prdata_q <= {24'h00_0000, r8_q, t8_q, single_wire_tx_direction_q, 1'b0,
              overrun_irq_enable_q, noise_irq_enable_q, framing_irq_enable_q, parity_irq_enable_q};
          `SCP_OFF_DATA: prdata_q <= {24'h00_0000, rbuf_q};
          default: pslverr_q <= 1'b1;
        endcase
    end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign txd_o = txd_q;
  assign txd_oe_o = oe_q;
  assign err_irq_o = irq_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_valid_start;
    bt_q && rx_st_q == RX_START && rt_q == 4'h6 && !maj;
  endsequence
  a_raf_on_start: assert property (s_valid_start |=> raf_q)
    else $error("activity flag not set on valid start");
  a_s2_write_inert: assert property (wr_fire && paddr_i == `SCP_OFF_STAT2 |=>
    $stable(ctrl_q) && $stable(baud_q) && $stable(t8_q))
    else $error("status 2 write changed state");
  a_ninth_rx_bit: assert property (load |=> r8_q == $past(fr_d_q[8]))
    else $error("ninth receive bit not loaded");
  a_ninth_tx_bit: assert property (take && m |=> tsh_q[9] == $past(t8_q))
    else $error("ninth transmit bit not in shifter");
  a_frame_length: assert property (take |=> tcnt_q == (m ? 4'hb : 4'ha))
    else $error("wrong frame length");
  a_ovr_irq: assert property (ovr_q && overrun_irq_enable_q |=> irq_q)
    else $error("overrun interrupt missing");
  a_nf_irq: assert property (nf_q && noise_irq_enable_q |=> irq_q)
    else $error("noise interrupt missing");
  a_fe_irq: assert property (fe_q && framing_irq_enable_q |=> irq_q)
    else $error("framing interrupt missing");
  a_pf_irq: assert property (pf_q && parity_irq_enable_q |=> irq_q)
    else $error("parity interrupt missing");
  a_no_irq: assert property (!((ovr_q & overrun_irq_enable_q) | (nf_q & noise_irq_enable_q) | (fe_q & framing_irq_enable_q)
    | (pf_q & parity_irq_enable_q)) |=> !irq_q)
    else $error("spurious error interrupt");
  a_baud_stopped: assert property (baud_q == 13'h0000 |=> !bt_q)
    else $error("baud tick while stopped");
  a_single_wire: assert property (ctrl_q[`SCP_CTRL_LOOP_SELECT] && ctrl_q[`SCP_CTRL_RECEIVER_SOURCE_SELECT]
    && !single_wire_tx_direction_q ##1 $stable(ctrl_q) && !single_wire_tx_direction_q |=> !oe_q)
    else $error("pin driven in single-wire input mode");
endmodule : scp_serial_port

// [dv/scp_remote_dev.sv]
// remote serial device model: sends frames to the port and captures its frames
`timescale 1ns/1ps
module scp_remote_dev #(
  parameter int DIV = 4
)(
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  // exact rate, well inside the receiver's mismatch budget
  localparam int BIT = 16 * DIV;
  logic [10:0] cap_q;

  // line idles high between frames
  initial rxd_o = 1'b1;

  // start, n data bits lsb first, stop; a low stop makes a framing fault
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    for (int i = 0; i <= n + 1; i++)
    begin
      rxd_o <= (i == 0) ? 1'b0 : (i > n) ? stop : d[i - 1];
      repeat (BIT) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send

  // eight-bit frame; a glitch one tick long hits exactly one centre sample of data bit 0
  task automatic send_noisy(input logic [7:0] d);
    for (int i = 0; i <= 9; i++)
    begin
      rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
      if (i == 1)
      begin
        repeat (8 * DIV - 1) @(posedge clk_i);
        rxd_o <= ~d[0];
        repeat (DIV) @(posedge clk_i);
        rxd_o <= d[0];
        repeat (BIT - 9 * DIV + 1) @(posedge clk_i);
      end
      else
        repeat (BIT) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send_noisy

  // sample each bit at its middle, start bit into cap_q[0]
  task automatic recv(input int n);
    cap_q = '0;
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i <= n + 1; i++)
    begin
      cap_q[i] = txd_i;
      repeat (BIT) @(posedge clk_i);
    end
  endtask : recv
endmodule : scp_remote_dev

// [dv/scp_serial_port_tb.sv]
// self-checking bench for the serial port
`timescale 1ns/1ps
`include "scp_cfg.svh"
module scp_serial_port_tb;
  localparam int BIT = 64;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic pready_o, pslverr_o, er, rxd_i, txd_pin_i, txd_o, txd_oe_o, err_irq_o;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  scp_serial_port uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i),
    .txd_pin_i(txd_pin_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .err_irq_o(err_irq_o));
  scp_remote_dev #(.DIV(4)) far (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // pin has a pull-up, so a released pin reads high
  assign txd_pin_i = txd_oe_o ? txd_o : 1'b1;

  initial forever #50 clk_i = ~clk_i;

  // hang guard, a few times the expected run
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask : rdm

  // irq is a registered level: let it settle before looking
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk_i);
    chk({31'h0000_0000, err_irq_o}, {31'h0000_0000, e});
  endtask : irq_is

  task automatic t_regs();
    rdm(`SCP_OFF_STAT2, 32'hffff_ffff, 32'h0000_0000);
    wr(`SCP_OFF_STAT2, 32'h0000_00ff);
    rdm(`SCP_OFF_STAT2, 32'hffff_ffff, 32'h0000_0000);
    rdm(12'h018, 32'hffff_ffff, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    rdm(`SCP_OFF_BAUD, 32'hffff_ffff, {19'h0_0000, `SCP_BAUD_RST});
    $display("test regs done");
  endtask : t_regs

  task automatic t_rx8();
    wr(`SCP_OFF_CTRL, 32'h0000_0003);
    fork
      far.send(9'h0a5, 8, 1'b1);
      begin
        repeat (3 * BIT) @(posedge clk_i);
        rdm(`SCP_OFF_STAT2, 32'h0000_0001, 32'h0000_0001);
      end
    join
    rdm(`SCP_OFF_STAT1, 32'h0000_0020, 32'h0000_0020);
    rdm(`SCP_OFF_DATA, 32'hffff_ffff, 32'h0000_00a5);
    rdm(`SCP_OFF_STAT1, 32'h0000_0020, 32'h0000_0000);
    repeat (14 * BIT) @(posedge clk_i);
    rdm(`SCP_OFF_STAT2, 32'h0000_0001, 32'h0000_0000);
    $display("test rx8 done");
  endtask : t_rx8

  // ninth bit fetched before the data read, which frees the buffer
  task automatic t_rx9();
    wr(`SCP_OFF_CTRL, 32'h0000_0007);
    far.send(9'h13c, 9, 1'b1);
    apb(1'b0, `SCP_OFF_STAT1, 32'h0000_0000);
    rdm(`SCP_OFF_CTRL3, 32'h0000_0080, 32'h0000_0080);
    rdm(`SCP_OFF_DATA, 32'hffff_ffff, 32'h0000_003c);
    far.send(9'h0c3, 9, 1'b1);
    apb(1'b0, `SCP_OFF_STAT1, 32'h0000_0000);
    rdm(`SCP_OFF_CTRL3, 32'h0000_0080, 32'h0000_0000);
    rdm(`SCP_OFF_DATA, 32'hffff_ffff, 32'h0000_00c3);
    $display("test rx9 done");
  endtask : t_rx9

  task automatic t_tx();
    wr(`SCP_OFF_CTRL3, 32'h0000_0040);
    fork
      far.recv(9);
      wr(`SCP_OFF_DATA, 32'h0000_005a);
    join
    chk({21'h0, far.cap_q}, {21'h0, 11'b11_0101_1010_0});
    fork
      far.recv(9);
      wr(`SCP_OFF_DATA, 32'h0000_0081);
    join
    chk({21'h0, far.cap_q}, {21'h0, 11'b11_1000_0001_0});
    wr(`SCP_OFF_CTRL, 32'h0000_0003);
    fork
      far.recv(8);
      wr(`SCP_OFF_DATA, 32'h0000_00f0);
    join
    chk({21'h0, far.cap_q}, {21'h0, 11'b01_1111_0000_0});
    $display("test tx done");
  endtask : t_tx

  // modulo zero freezes the transmitter; restoring it lets the pending frame out
  task automatic t_baud();
    wr(`SCP_OFF_BAUD, 32'h0000_0000);
    wr(`SCP_OFF_DATA, 32'h0000_0000);
    repeat (2 * BIT) @(posedge clk_i);
    chk({31'h0, txd_o}, 32'h0000_0001);
    rdm(`SCP_OFF_STAT1, 32'h0000_0080, 32'h0000_0000);
    fork
      far.recv(8);
      wr(`SCP_OFF_BAUD, {19'h0_0000, `SCP_BAUD_RST});
    join
    chk({21'h0, far.cap_q}, {21'h0, 11'b010_0000_0000});
    $display("test baud done");
  endtask : t_baud

  // internal loop: own frame comes back through the receiver
  task automatic t_loop();
    wr(`SCP_OFF_CTRL, 32'h0000_0013);
    wr(`SCP_OFF_DATA, 32'h0000_0096);
    repeat (13 * BIT) @(posedge clk_i);
    rdm(`SCP_OFF_STAT1, 32'h0000_0020, 32'h0000_0020);
    rdm(`SCP_OFF_DATA, 32'hffff_ffff, 32'h0000_0096);
    wr(`SCP_OFF_CTRL, 32'h0000_0003);
    $display("test loop done");
  endtask : t_loop

  task automatic t_swire();
    wr(`SCP_OFF_CTRL, 32'h0000_0033);
    wr(`SCP_OFF_CTRL3, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk({31'h0, txd_oe_o}, 32'h0000_0000);
    wr(`SCP_OFF_CTRL3, 32'h0000_0020);
    repeat (3) @(posedge clk_i);
    chk({31'h0, txd_oe_o}, 32'h0000_0001);
    wr(`SCP_OFF_CTRL, 32'h0000_0003);
    $display("test single wire done");
  endtask : t_swire

  // framing fault and noise each masked then enabled then cleared; overrun and parity enabled then cleared
  task automatic t_err();
    wr(`SCP_OFF_CTRL3, 32'h0000_0000);
    far.send(9'h055, 8, 1'b0);
    // low stop re-arms the start search at once: let the phantom frame pass while fe holds
    repeat (12 * BIT) @(posedge clk_i);
    irq_is(1'b0);
    wr(`SCP_OFF_CTRL3, 32'h0000_0002);
    irq_is(1'b1);
    rdm(`SCP_OFF_STAT1, 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, `SCP_OFF_DATA, 32'h0000_0000);
    irq_is(1'b0);
    wr(`SCP_OFF_CTRL3, 32'h0000_0008);
    far.send(9'h011, 8, 1'b1);
    far.send(9'h022, 8, 1'b1);
    irq_is(1'b1);
    rdm(`SCP_OFF_STAT1, 32'h0000_0008, 32'h0000_0008);
    rdm(`SCP_OFF_DATA, 32'hffff_ffff, 32'h0000_0011);
    irq_is(1'b0);
    wr(`SCP_OFF_CTRL, 32'h0000_000b);
    wr(`SCP_OFF_CTRL3, 32'h0000_0001);
    far.send(9'h001, 8, 1'b1);
    irq_is(1'b1);
    rdm(`SCP_OFF_STAT1, 32'h0000_0001, 32'h0000_0001);
    apb(1'b0, `SCP_OFF_DATA, 32'h0000_0000);
    irq_is(1'b0);
    wr(`SCP_OFF_CTRL3, 32'h0000_0000);
    far.send_noisy(8'h3c);
    irq_is(1'b0);
    wr(`SCP_OFF_CTRL3, 32'h0000_0004);
    irq_is(1'b1);
    rdm(`SCP_OFF_STAT1, 32'h0000_0004, 32'h0000_0004);
    rdm(`SCP_OFF_DATA, 32'hffff_ffff, 32'h0000_003c);
    irq_is(1'b0);
    $display("test errors done");
  endtask : t_err

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_rx8();
    t_rx9();
    t_tx();
    t_baud();
    t_swire();
    t_loop();
    t_err();
    end_of_test();
  end
endmodule : scp_serial_port_tb
